// file: bench/instr_decode_monitor.sv
// Port checker for the instruction decode core
`timescale 1ns/1ps
`include "tbd_consts.vh"
module instr_decode_monitor #(
  parameter FILE_DEPTH = 32,
  parameter OSC_PER_CYCLE = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire [11:0] instr_i,
  input wire instr_valid_i,
  input wire instr_ready_o,
  input wire [8:0] pc_o,
  input wire done_o,
  input wire unimpl_o
);
  logic [11:0] cap;
  logic [8:0] cap_pc;
  wire take = instr_valid_i && instr_ready_o;
  wire is_jmp = cap[11:9] == `TBD_OPC_ABS_JUMP;
  wire known = cap[11:6] == `TBD_OPC_ADD_ACC_FILE ||
    cap[11:6] == `TBD_OPC_AND_ACC_FILE || cap[11:8] == `TBD_OPC_BIT_CLEAR ||
    cap[11:8] == `TBD_OPC_BIT_SET || cap[11:8] == `TBD_OPC_AND_LIT_ACC ||
    is_jmp;
  // Remember the word and count taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      cap <= 12'h000;
      cap_pc <= 9'h000;
    end else if (take) begin
      cap <= instr_i;
      cap_pc <= pc_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // Assertions
  // ****************
  property p_take_done; take |-> ##5 done_o; endproperty
  a_take_done: assert property (p_take_done)
    else $error("no completion after a taken word");
  property p_busy; take |=> !instr_ready_o [*3]; endproperty
  a_busy: assert property (p_busy)
    else $error("word taken while busy");
  property p_done_pulse; done_o |=> !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion pulse too long");
  property p_pc_step; done_o && !is_jmp |-> pc_o == cap_pc + 9'h1; endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("count did not step by one");
  property p_pc_jump; done_o && is_jmp |-> pc_o == cap[8:0]; endproperty
  a_pc_jump: assert property (p_pc_jump)
    else $error("jump target not loaded");
  property p_jmp_hold; done_o && is_jmp |-> !instr_ready_o [*3]; endproperty
  a_jmp_hold: assert property (p_jmp_hold)
    else $error("jump second cycle skipped");
  property p_unimpl_set; done_o && !known |-> unimpl_o; endproperty
  a_unimpl_set: assert property (p_unimpl_set)
    else $error("unknown word not flagged");
  property p_unimpl_clr; done_o && known |-> !unimpl_o; endproperty
  a_unimpl_clr: assert property (p_unimpl_clr)
    else $error("known word flagged");
  property p_unimpl_pulse; unimpl_o |-> done_o; endproperty
  a_unimpl_pulse: assert property (p_unimpl_pulse)
    else $error("flag outside completion");
  property p_bus_block; avs_read_i || avs_write_i |-> !instr_ready_o;
  endproperty
  a_bus_block: assert property (p_bus_block)
    else $error("ready during bus request");
  property p_wait_bound;
    avs_read_i || avs_write_i |-> ##[0:12] !avs_waitrequest_o;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("bus stalled too long");
endmodule
bind instr_decode_core instr_decode_monitor #(
  .FILE_DEPTH(FILE_DEPTH),
  .OSC_PER_CYCLE(OSC_PER_CYCLE)
) u_instr_decode_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .instr_i(instr_i), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .pc_o(pc_o), .done_o(done_o),
  .unimpl_o(unimpl_o)
);

// file: bench/prog_mem_model.sv
// Program memory model that feeds instruction words to the core
`timescale 1ns/1ps
module prog_mem_model (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [3:0] burst_i,
  input wire slow_i,
  input wire [8:0] pc_i,
  input wire instr_ready_i,
  output logic [11:0] instr_o,
  output logic instr_valid_o
);
  logic [11:0] mem [0:511];
  logic [3:0] left;
  logic [1:0] gap;
  logic [11:0] last;
  // Count words left in the burst; slow mode leaves a gap after each
  always @(posedge clk_i) begin
    if (rst_i) begin
      left <= 4'h0;
      gap <= 2'h0;
      last <= 12'h000;
    end else if (start_i) begin
      left <= burst_i;
      gap <= slow_i ? 2'h3 : 2'h0;
    end else if (instr_valid_o && instr_ready_i) begin
      left <= left - 4'h1;
      gap <= slow_i ? 2'h3 : 2'h0;
      last <= instr_o;
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end
  end
  // Whole twelve-bit word at the current count; inverted junk when idle
  assign instr_valid_o = (left != 4'h0) && (gap == 2'h0);
  assign instr_o = instr_valid_o ? mem[pc_i] : ~last;
endmodule

// file: bench/twelve_bit_instruction_decode_tb.sv
// Self-checking bench for the instruction decode core
`timescale 1ns/1ps
`include "tbd_consts.vh"
module twelve_bit_instruction_decode_tb;
  typedef struct {
    logic [11:0] iw;
    logic [7:0] acc, fil;
    logic [2:0] st0;
    logic [7:0] eacc, efil;
    logic [3:0] est;
  } row_t;
  logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rv;
  logic [3:0] avs_byteenable_i = 4'h0, burst_i = 4'h0;
  logic avs_waitrequest_o, instr_valid_i, instr_ready_o, done_o, unimpl_o;
  logic start_i = 0, slow_i = 0;
  logic [11:0] instr_i;
  logic [8:0] pc_o, epc;
  logic [7:0] fa;
  int n_errors = 0, cmp_count = 0;
  row_t r;
  row_t rows [14] = '{
    '{12'h1c3, 8'h0f, 8'h01, 3'h0, 8'h10, 8'h01, 4'h2},
    '{12'h1ff, 8'h80, 8'h80, 3'h0, 8'h80, 8'h00, 4'h5},
    '{12'h1e0, 8'hff, 8'h01, 3'h0, 8'hff, 8'h00, 4'h7},
    '{12'h145, 8'hf0, 8'h3c, 3'h3, 8'h30, 8'h3c, 4'h3},
    '{12'h171, 8'h0f, 8'hf0, 3'h0, 8'h0f, 8'h00, 4'h4},
    '{12'h4ff, 8'h12, 8'hff, 3'h5, 8'h12, 8'h7f, 4'h5},
    '{12'h402, 8'h55, 8'h01, 3'h2, 8'h55, 8'h00, 4'h2},
    '{12'h509, 8'h00, 8'h00, 3'h4, 8'h00, 8'h01, 4'h4},
    '{12'h5fe, 8'h00, 8'h00, 3'h3, 8'h00, 8'h80, 4'h3},
    '{12'he0f, 8'hf3, 8'haa, 3'h7, 8'h03, 8'haa, 4'h3},
    '{12'he00, 8'hff, 8'h33, 3'h0, 8'h00, 8'h33, 4'h4},
    '{12'hfff, 8'h44, 8'h99, 3'h6, 8'h44, 8'h99, 4'he},
    '{12'hba5, 8'h21, 8'h66, 3'h1, 8'h21, 8'h66, 4'h1},
    '{12'h000, 8'h01, 8'h02, 3'h0, 8'h01, 8'h02, 4'h8}};
  // Clock at 50 MHz
  always #10 clk_i = ~clk_i;
  instr_decode_core u_instr_decode_core (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .pc_o(pc_o), .done_o(done_o),
    .unimpl_o(unimpl_o));
  prog_mem_model u_prog_mem_model (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .burst_i(burst_i),
    .slow_i(slow_i), .pc_i(pc_o), .instr_ready_i(instr_ready_o),
    .instr_o(instr_i), .instr_valid_o(instr_valid_i));
  // ****************
  // Tasks
  // ****************
  task close_out;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int k;
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      close_out();
    end
    rv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // Arm the memory for n words and wait for n completions
  task run(input logic [3:0] n, input logic s);
    int k, seen;
    seen = 0;
    @(posedge clk_i);
    start_i <= 1'b1;
    burst_i <= n;
    slow_i <= s;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (k = 0; k < 200 && seen < n; k++) begin
      @(posedge clk_i);
      if (done_o === 1'b1) seen++;
    end
    if (seen < n) begin
      n_errors++;
      close_out();
    end
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1, `TBD_REG_CTRL, 32'h1, 4'h1);
    epc = 9'h000;
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      fa = `TBD_REG_FILE_BASE + {1'b0, r.iw[4:0], 2'b00};
      bus(1, `TBD_REG_ACC, {24'h0, r.acc}, 4'h1);
      bus(1, fa, {24'h0, r.fil}, 4'h1);
      bus(1, `TBD_REG_STATUS, {28'h0, 1'b1, r.st0}, 4'h1);
      u_prog_mem_model.mem[epc] = r.iw;
      run(4'h1, i[0]);
      epc = (r.iw[11:9] == 3'h5) ? r.iw[8:0] : epc + 9'h1;
      chk("pc", {23'h0, pc_o}, {23'h0, epc});
      bus(0, `TBD_REG_ACC, 32'h0, 4'h1);
      chk("acc", rv, {24'h0, r.eacc});
      bus(0, fa, 32'h0, 4'h1);
      chk("file", rv, {24'h0, r.efil});
      bus(0, `TBD_REG_STATUS, 32'h0, 4'h1);
      chk("status", {28'h0, rv[3:0]}, {28'h0, r.est});
    end
    // Three words back to back: literal AND, add, bit set
    bus(1, `TBD_REG_ACC, 32'hff, 4'h1);
    bus(1, 8'h84, 32'hf1, 4'h1);
    bus(1, `TBD_REG_STATUS, 32'h8, 4'h1);
    u_prog_mem_model.mem[epc] = 12'he0f;
    u_prog_mem_model.mem[epc + 9'h1] = 12'h1c1;
    u_prog_mem_model.mem[epc + 9'h2] = 12'h561;
    run(4'h3, 1'b0);
    chk("pc", {23'h0, pc_o}, {23'h0, epc + 9'h3});
    bus(0, `TBD_REG_PC, 32'h0, 4'h1);
    chk("pc reg", rv, {23'h0, epc + 9'h3});
    bus(0, `TBD_REG_LAST, 32'h0, 4'h1);
    chk("last word", rv, 32'h561);
    bus(0, `TBD_REG_ACC, 32'h0, 4'h1);
    chk("acc", rv, 32'h0);
    bus(0, 8'h84, 32'h0, 4'h1);
    chk("file", rv, 32'hf9);
    bus(0, `TBD_REG_STATUS, 32'h0, 4'h1);
    chk("status", {28'h0, rv[3:0]}, 32'h7);
    // Refused writes: no byte enable, unmapped place
    bus(1, `TBD_REG_ACC, 32'h5a, 4'h0);
    bus(0, `TBD_REG_ACC, 32'h0, 4'h1);
    chk("acc", rv, 32'h0);
    bus(1, 8'h40, 32'h5a, 4'h1);
    bus(0, 8'h40, 32'h0, 4'h1);
    chk("unmapped", rv, 32'h0);
    // Reset while the core is idle between runs clears the core state
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pc", {23'h0, pc_o}, 32'h0);
    bus(0, `TBD_REG_ACC, 32'h0, 4'h1);
    chk("acc", rv, 32'h0);
    bus(0, `TBD_REG_STATUS, 32'h0, 4'h1);
    chk("status", rv, 32'h0);
    close_out();
  end
endmodule

// file: rtl/instr_alu.v
// Eight-bit arithmetic and bit logic with flag results
`timescale 1ns/1ps
`include "tbd_consts.vh"

module instr_alu (
  input wire [2:0] op_i,
  input wire [7:0] acc_i,
  input wire [7:0] file_i,
  input wire [7:0] k8_i,
  input wire [2:0] bitpos_i,
  output reg [7:0] result_o,
  output reg carry_o,
  output reg half_carry_flag_o,
  output wire zero_o
);

  reg [8:0] sum;
  reg [4:0] low_sum;
  reg [7:0] mask;

  // Result per operation; carries always taken from the add
  always @* begin
    sum = {1'b0, acc_i} + {1'b0, file_i};
    low_sum = {1'b0, acc_i[3:0]} + {1'b0, file_i[3:0]};
    mask = 8'h01 << bitpos_i;
    result_o = 8'h00;
    carry_o = sum[8];
    half_carry_flag_o = low_sum[4];
    case (op_i)
      `TBD_OP_ADD: result_o = sum[7:0];
      `TBD_OP_ANDF: result_o = acc_i & file_i;
      `TBD_OP_ANDL: result_o = acc_i & k8_i;
      `TBD_OP_BCLR: result_o = file_i & ~mask;
      `TBD_OP_BSET: result_o = file_i | mask;
      default: result_o = 8'h00;
    endcase
  end

  // Zero test of the eight-bit result
  assign zero_o = (result_o == 8'h00);

endmodule

// file: rtl/instr_decode_core.v
// Instruction decode and execute core with Avalon-MM register access
// Function
// - Byte ops: opcode 11..6, destination bit 5, file address 4..0.
// - Bit ops: opcode 11..8, bit position 7..5, file address 4..0.
// - Literal ops: opcode 11..8, eight-bit immediate 7..0.
// - Absolute jump: opcode 11..9, nine-bit target 8..0.
// - Destination 0 writes accumulator, 1 writes the file register.
// - File field covers registers 0..31, bit field bits 0..7.
// - Add accumulator and file; route sum; update carry, half, zero.
// - Bit clear zeroes the chosen bit only; flags untouched.
// - Bit set forces the chosen bit to one; flags untouched.
// - AND literal into accumulator, updating only zero flag.
// - AND accumulator with file into destination, zero flag only.
// - Every instruction word is twelve bits: opcode plus operands.
// - Listed instructions finish in one cycle of four periods; the jump spends a second cycle in ST_FLUSH.
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "tbd_consts.vh"

module instr_decode_core #(
  parameter FILE_DEPTH = 32,
  parameter OSC_PER_CYCLE = `TBD_OSC_PER_CYCLE
) (
  input wire clk_i,
  input wire rst_i,
  // Avalon-MM slave
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Program memory side
  input wire [11:0] instr_i,
  input wire instr_valid_i,
  output wire instr_ready_o,
  // Core state
  output reg [8:0] pc_o,
  output reg done_o,
  output reg unimpl_o
);

  // ******************************************************************
  // Sequencer states
  // ******************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_FLUSH = 2'h2;
  localparam [1:0] LAST_PHASE = OSC_PER_CYCLE[1:0] - 2'h1;

  // ******************************************************************
  // Storage
  // ******************************************************************
  reg [7:0] file_mem [0:FILE_DEPTH-1];
  reg [7:0] acc;
  reg carry;
  reg half_carry_flag;
  reg zero;
  reg unimpl_seen;
  reg run;
  reg [11:0] ir;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] phase;
  reg rd_done;
  integer i;

  wire [2:0] op;
  wire dest;
  wire [4:0] file_sel;
  wire [2:0] bitpos;
  wire [7:0] k8;
  wire [8:0] k9;
  wire [7:0] alu_result;
  wire alu_carry;
  wire alu_half;
  wire alu_zero;
  wire busy;
  wire bus_req;
  wire retire;
  wire accept;
  wire bus_wr;
  wire [7:0] st_wbits;

  // ******************************************************************
  // Address decode helpers
  // ******************************************************************
  // True when the byte address falls in the file window
  function file_hit;
    input [7:0] addr;
    begin
      file_hit = (addr >= `TBD_REG_FILE_BASE) &&
                 (addr[1:0] == 2'b00) &&
                 (addr[6:2] < FILE_DEPTH);
    end
  endfunction

  // File index carried by a file window address
  function [4:0] file_idx;
    input [7:0] addr;
    begin
      file_idx = addr[6:2];
    end
  endfunction

  // ******************************************************************
  // Decode and arithmetic
  // ******************************************************************
  instr_field_decode u_decode (
    .instr_i(ir),
    .op_o(op),
    .dest_o(dest),
    .file_o(file_sel),
    .bitpos_o(bitpos),
    .k8_o(k8),
    .k9_o(k9)
  );

  instr_alu u_alu (
    .op_i(op),
    .acc_i(acc),
    .file_i(file_mem[file_sel]),
    .k8_i(k8),
    .bitpos_i(bitpos),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .half_carry_flag_o(alu_half),
    .zero_o(alu_zero)
  );

  // ******************************************************************
  // Handshakes
  // ******************************************************************
  // Bus is held off while an instruction is in flight
  assign busy = (state != ST_IDLE);
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = (bus_req & busy) |
                             (avs_read_i & ~rd_done);
  assign bus_wr = avs_write_i & ~busy & avs_byteenable_i[0];
  // A new word only enters when idle, enabled and the bus is quiet
  assign instr_ready_o = ~busy & run & ~bus_req;
  assign accept = instr_ready_o & instr_valid_i;
  // Last oscillator period of the instruction cycle
  assign retire = (state == ST_EXEC) && (phase == LAST_PHASE);

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  // Next state selection
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (retire) begin
          // A jump spends a second cycle refetching
          next_state = (op == `TBD_OP_JMP) ? ST_FLUSH : ST_IDLE;
        end
      end
      ST_FLUSH: begin
        if (phase == LAST_PHASE) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State, phase count and latched instruction word
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      ir <= 12'h000;
    end else begin
      state <= next_state;
      if (accept) begin
        ir <= instr_i;
      end
      if (state == ST_IDLE) begin
        phase <= 2'h0;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  // ******************************************************************
  // Execute: accumulator and flags
  // ******************************************************************
  // Writeback at the end of the instruction cycle, or software write
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc <= 8'h00;
      carry <= 1'b0;
      half_carry_flag <= 1'b0;
      zero <= 1'b0;
    end else if (retire) begin
      case (op)
        `TBD_OP_ADD: begin
          if (!dest) begin
            acc <= alu_result;
          end
          carry <= alu_carry;
          half_carry_flag <= alu_half;
          zero <= alu_zero;
        end
        `TBD_OP_ANDF: begin
          if (!dest) begin
            acc <= alu_result;
          end
          zero <= alu_zero;
        end
        `TBD_OP_ANDL: begin
          acc <= alu_result;
          zero <= alu_zero;
        end
        default: begin
          // Bit ops, jump and unknown words leave these alone
          acc <= acc;
        end
      endcase
    end else if (bus_wr) begin
      if (avs_address_i == `TBD_REG_ACC) begin
        acc <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `TBD_REG_STATUS) begin
        carry <= st_wbits[`TBD_ST_CARRY];
        half_carry_flag <= st_wbits[`TBD_ST_HALF];
        zero <= st_wbits[`TBD_ST_ZERO];
      end
    end
  end

  assign st_wbits = avs_writedata_i[7:0];

  // ******************************************************************
  // Execute: file registers
  // ******************************************************************
  // File writeback for destination one and bit ops, or software write
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < FILE_DEPTH; i = i + 1) begin
        file_mem[i] <= 8'h00;
      end
    end else if (retire) begin
      case (op)
        `TBD_OP_ADD, `TBD_OP_ANDF: begin
          if (dest) begin
            file_mem[file_sel] <= alu_result;
          end
        end
        `TBD_OP_BCLR, `TBD_OP_BSET: begin
          file_mem[file_sel] <= alu_result;
        end
        default: begin
          file_mem[file_sel] <= file_mem[file_sel];
        end
      endcase
    end else if (bus_wr && file_hit(avs_address_i)) begin
      file_mem[file_idx(avs_address_i)] <= avs_writedata_i[7:0];
    end
  end

  // ******************************************************************
  // Program counter, completion and unknown-word flag
  // ******************************************************************
  // Jump loads the target; others step past themselves
  always @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= 9'h000;
      done_o <= 1'b0;
      unimpl_o <= 1'b0;
    end else begin
      done_o <= retire;
      unimpl_o <= retire && (op == `TBD_OP_NONE);
      if (retire) begin
        if (op == `TBD_OP_JMP) begin
          pc_o <= k9;
        end else begin
          pc_o <= pc_o + 9'h001;
        end
      end
    end
  end

  // Sticky unknown-word status; a new event beats a clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      unimpl_seen <= 1'b0;
    end else if (retire && (op == `TBD_OP_NONE)) begin
      unimpl_seen <= 1'b1;
    end else if (bus_wr && (avs_address_i == `TBD_REG_STATUS) &&
                 st_wbits[`TBD_ST_UNIMPL]) begin
      unimpl_seen <= 1'b0;
    end
  end

  // ******************************************************************
  // Control register
  // ******************************************************************
  // Run enable gates acceptance of new words
  always @(posedge clk_i) begin
    if (rst_i) begin
      run <= `TBD_CTRL_RESET;
    end else if (bus_wr && (avs_address_i == `TBD_REG_CTRL)) begin
      run <= avs_writedata_i[`TBD_CTRL_RUN];
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  // Read data captured one cycle after the request, then released
  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
      rd_done <= 1'b0;
    end else if (rd_done) begin
      rd_done <= 1'b0;
    end else if (avs_read_i && !busy) begin
      rd_done <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      if (file_hit(avs_address_i)) begin
        avs_readdata_o[7:0] <= file_mem[file_idx(avs_address_i)];
      end else begin
        case (avs_address_i)
          `TBD_REG_CTRL: avs_readdata_o[`TBD_CTRL_RUN] <= run;
          `TBD_REG_ACC: avs_readdata_o[7:0] <= acc;
          `TBD_REG_STATUS: begin
            avs_readdata_o[`TBD_ST_CARRY] <= carry;
            avs_readdata_o[`TBD_ST_HALF] <= half_carry_flag;
            avs_readdata_o[`TBD_ST_ZERO] <= zero;
            avs_readdata_o[`TBD_ST_UNIMPL] <= unimpl_seen;
            avs_readdata_o[`TBD_ST_BUSY] <= busy;
          end
          `TBD_REG_PC: avs_readdata_o[8:0] <= pc_o;
          `TBD_REG_LAST: avs_readdata_o[11:0] <= ir;
          default: avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: rtl/instr_field_decode.v
// Field extraction and operation classing of one instruction word
`timescale 1ns/1ps
`include "tbd_consts.vh"

module instr_field_decode (
  input wire [11:0] instr_i,
  output reg [2:0] op_o,
  output wire dest_o,
  output wire [4:0] file_o,
  output wire [2:0] bitpos_o,
  output wire [7:0] k8_o,
  output wire [8:0] k9_o
);

  // Operand fields of each layout
  assign dest_o = instr_i[`TBD_DEST_BIT];
  assign file_o = instr_i[`TBD_FILE_HI:`TBD_FILE_LO];
  assign bitpos_o = instr_i[`TBD_BITPOS_HI:`TBD_BITPOS_LO];
  assign k8_o = instr_i[`TBD_K8_HI:0];
  assign k9_o = instr_i[`TBD_K9_HI:0];

  // Opcode classing, longest opcode first
  always @* begin
    op_o = `TBD_OP_NONE;
    if (instr_i[`TBD_BYTE_OP_HI:`TBD_BYTE_OP_LO] ==
        `TBD_OPC_ADD_ACC_FILE) begin
      op_o = `TBD_OP_ADD;
    end else if (instr_i[`TBD_BYTE_OP_HI:`TBD_BYTE_OP_LO] ==
        `TBD_OPC_AND_ACC_FILE) begin
      op_o = `TBD_OP_ANDF;
    end else if (instr_i[`TBD_BIT_OP_HI:`TBD_BIT_OP_LO] ==
        `TBD_OPC_BIT_CLEAR) begin
      op_o = `TBD_OP_BCLR;
    end else if (instr_i[`TBD_BIT_OP_HI:`TBD_BIT_OP_LO] ==
        `TBD_OPC_BIT_SET) begin
      op_o = `TBD_OP_BSET;
    end else if (instr_i[`TBD_LIT_OP_HI:`TBD_LIT_OP_LO] ==
        `TBD_OPC_AND_LIT_ACC) begin
      op_o = `TBD_OP_ANDL;
    end else if (instr_i[`TBD_JMP_OP_HI:`TBD_JMP_OP_LO] ==
        `TBD_OPC_ABS_JUMP) begin
      op_o = `TBD_OP_JMP;
    end
  end

endmodule

// file: rtl/tbd_consts.vh
// Constants for the twelve-bit instruction decode block
`ifndef TBD_CONSTS_VH
`define TBD_CONSTS_VH

// ********************************************************************
// Instruction word fields
// ********************************************************************
`define TBD_IW 12
`define TBD_BYTE_OP_HI 11
`define TBD_BYTE_OP_LO 6
`define TBD_DEST_BIT 5
`define TBD_FILE_HI 4
`define TBD_FILE_LO 0
`define TBD_BIT_OP_HI 11
`define TBD_BIT_OP_LO 8
`define TBD_BITPOS_HI 7
`define TBD_BITPOS_LO 5
`define TBD_LIT_OP_HI 11
`define TBD_LIT_OP_LO 8
`define TBD_K8_HI 7
`define TBD_K9_HI 8
`define TBD_JMP_OP_HI 11
`define TBD_JMP_OP_LO 9

// ********************************************************************
// Opcode encodings
// ********************************************************************
`define TBD_OPC_ADD_ACC_FILE 6'h07
`define TBD_OPC_AND_ACC_FILE 6'h05
`define TBD_OPC_BIT_CLEAR 4'h4
`define TBD_OPC_BIT_SET 4'h5
`define TBD_OPC_AND_LIT_ACC 4'he
`define TBD_OPC_ABS_JUMP 3'h5

// ********************************************************************
// Internal operation classes
// ********************************************************************
`define TBD_OP_ADD 3'h0
`define TBD_OP_ANDF 3'h1
`define TBD_OP_ANDL 3'h2
`define TBD_OP_BCLR 3'h3
`define TBD_OP_BSET 3'h4
`define TBD_OP_JMP 3'h5
`define TBD_OP_NONE 3'h7

// ********************************************************************
// Timing: oscillator periods per instruction cycle
// ********************************************************************
`define TBD_OSC_PER_CYCLE 4

// ********************************************************************
// Register map (byte addresses) and fields
// ********************************************************************
`define TBD_REG_CTRL 8'h00
`define TBD_REG_ACC 8'h04
`define TBD_REG_STATUS 8'h08
`define TBD_REG_PC 8'h0c
`define TBD_REG_LAST 8'h10
`define TBD_REG_FILE_BASE 8'h80
`define TBD_CTRL_RUN 0
`define TBD_ST_CARRY 0
`define TBD_ST_HALF 1
`define TBD_ST_ZERO 2
`define TBD_ST_UNIMPL 3
`define TBD_ST_BUSY 4
`define TBD_CTRL_RESET 1'b0

`endif
